/* light_prox_pkg.sv */
/*
 * Shared constants and types for the light and proximity control block:
 * register offsets, reset values, field positions and timing counts.
 * Assumes a single 40 MHz clock and a byte-wide serial register port.
 */
package light_prox_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_STATE_ENABLES = 8'h80;
	localparam logic [7:0] OFF_LIGHT_INTEG = 8'h81;
	localparam logic [7:0] OFF_PROX_INTEG = 8'h82;
	localparam logic [7:0] OFF_LIGHT_WAIT = 8'h83;
	localparam logic [7:0] OFF_LIGHT_LO_LSB = 8'h84;
	localparam logic [7:0] OFF_LIGHT_LO_MSB = 8'h85;
	localparam logic [7:0] OFF_LIGHT_HI_LSB = 8'h86;
	localparam logic [7:0] OFF_LIGHT_HI_MSB = 8'h87;
	localparam logic [7:0] OFF_PROX_LO_LSB = 8'h88;
	localparam logic [7:0] OFF_PROX_LO_MSB = 8'h89;
	localparam logic [7:0] OFF_PROX_HI_LSB = 8'h8A;
	localparam logic [7:0] OFF_PROX_HI_MSB = 8'h8B;
	localparam logic [7:0] OFF_DEBOUNCE = 8'h8C;
	localparam logic [7:0] OFF_CONFIG_ZERO = 8'h8D;
	localparam logic [7:0] OFF_PROX_CONFIG_ZERO = 8'h8E;
	localparam logic [7:0] OFF_PROX_CONFIG_ONE = 8'h8F;
	localparam logic [7:0] OFF_PROX_CFG2 = 8'h90;
	localparam logic [7:0] OFF_REVISION = 8'h91;
	localparam logic [7:0] OFF_TYPE_CODE = 8'h92;
	localparam logic [7:0] OFF_CONFIG_ONE = 8'h93;
	localparam logic [7:0] OFF_FLAGS = 8'h94;
	localparam logic [7:0] OFF_LIGHT_B0 = 8'h95;
	localparam logic [7:0] OFF_LIGHT_B1 = 8'h96;
	localparam logic [7:0] OFF_LIGHT_B2 = 8'h97;
	localparam logic [7:0] OFF_IR_B0 = 8'h98;
	localparam logic [7:0] OFF_IR_B1 = 8'h99;
	localparam logic [7:0] OFF_IR_B2 = 8'h9A;
	localparam logic [7:0] OFF_PROX_B0 = 8'h9B;
	localparam logic [7:0] OFF_PROX_B1 = 8'h9C;
	localparam logic [7:0] OFF_VERSION_TWO = 8'hA6;
	localparam logic [7:0] OFF_SOFT_RESET = 8'hA8;
	localparam logic [7:0] OFF_PROX_WAIT = 8'hA9;
	localparam logic [7:0] OFF_CONFIG_THREE = 8'hAB;
	localparam logic [7:0] OFF_CONFIG_SIX = 8'hAE;
	localparam logic [7:0] OFF_PROX_OFS_LO = 8'hC0;
	localparam logic [7:0] OFF_PROX_OFS_HI = 8'hC1;
	localparam logic [7:0] OFF_TRIM_START = 8'hD7;
	localparam logic [7:0] OFF_TRIM_EXT = 8'hD8;
	localparam logic [7:0] OFF_TRIM_CTRL = 8'hD9;
	localparam logic [7:0] OFF_TRIM_STATE = 8'hDC;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hDD;
	localparam logic [7:0] OFF_LIGHT_SETUP = 8'hF5;
	localparam logic [7:0] OFF_PROX_TRIM_AUX = 8'hF6;

	// ****************************************
	// Reset values that are not zero
	// ****************************************
	localparam logic [7:0] RST_CONFIG_ZERO = 8'h50;
	localparam logic [7:0] RST_PROX_CONFIG_ZERO = 8'h8F;
	localparam logic [7:0] RST_PROX_CONFIG_ONE = 8'h32;
	localparam logic [7:0] RST_PROX_CFG2 = 8'h20;
	localparam logic [7:0] RST_CONFIG_ONE = 8'h68;
	localparam logic [7:0] RST_CONFIG_THREE = 8'h01;
	localparam logic [7:0] RST_CONFIG_SIX = 8'h3F;
	localparam logic [7:0] RST_TRIM_CTRL = 8'h50;
	localparam logic [7:0] RST_LIGHT_SETUP = 8'h18;
	localparam logic [7:0] RST_PROX_TRIM_AUX = 8'h60;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_POWER_ON = 0;
	localparam int BIT_LIGHT_ON = 1;
	localparam int BIT_PROX_ON = 2;
	localparam int BIT_LIGHT_WAIT_ON = 3;
	localparam int BIT_PROX_WAIT_ON = 4;
	localparam int BIT_LIGHT_X16 = 2;
	localparam int BIT_PROX_X16 = 3;
	localparam int BIT_WIDE_PROX = 3;
	localparam int BIT_PROX_IRQ = 5;
	localparam int BIT_LIGHT_IRQ = 4;

	// ****************************************
	// Timing and serial port
	// ****************************************
	localparam int STEP_NS = 2780000;
	localparam int CLK_NS = 25;
	localparam int STEP_CYCLES = STEP_NS / CLK_NS;
	localparam logic [6:0] DEV_ADDR = 7'h39;
	localparam logic [3:0] WAIT_X16 = 4'h4;
	localparam logic [5:0] LIGHT_DEBOUNCE_COUNTS_MAX = 6'h3C;

	// Converter results taken at the end of an integration
	typedef struct packed {
		logic [23:0] light;
		logic [23:0] ir;
		logic [15:0] prox;
	} sense_result_t;

	typedef enum logic [2:0] {SEQ_IDLE, SEQ_PROX, SEQ_PWAIT, SEQ_LIGHT, SEQ_LWAIT} seq_state_t;
	typedef enum logic [2:0] {SER_IDLE, SER_DEV, SER_PTR, SER_WR, SER_RD} ser_state_t;

endpackage : light_prox_pkg

/* light_prox_control_regs.sv */
/*
 * Register file, measurement sequencer, threshold compare and persistence
 * filters of the light and proximity sensor, reached over a two-wire
 * serial slave. Assumes the converters present results on conv_result and
 * that the pins reach this block asynchronously.
 */
`timescale 1ns/1ps
module light_prox_control_regs
	import light_prox_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES,
	parameter logic [7:0] REVISION_VAL = 8'h05, // Arbitrary value
	parameter logic [7:0] TYPE_VAL = 8'hA4, // Arbitrary value
	parameter logic [7:0] VERSION_VAL = 8'h03 // Arbitrary value
) (
	input wire logic ref_clk, // 40 MHz clock
	input wire logic rst, // Synchronous reset, high
	input wire logic scl_i, // Serial clock pin
	input wire logic sda_i, // Serial data pin level
	output logic sda_o, // Serial data drive level
	output logic sda_oe, // Serial data pulls low
	output logic int_o, // Interrupt drive level
	output logic int_oe, // Interrupt pulls low
	input wire sense_result_t conv_result, // Converter results
	output logic osc_run, // Oscillator and converters on
	output logic light_integ, // Light integration active
	output logic prox_integ // Prox integration active
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic scl_s1_r, scl_s2_r, scl_s3_r, scl_f_r;
	logic sda_s1_r, sda_s2_r, sda_s3_r, sda_f_r;
	logic scl_rise, scl_fall, start_c, stop_c;

	// Three stages; filtered level moves when the last two agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			{scl_s1_r, scl_s2_r, scl_s3_r, scl_f_r} <= 4'hF;
			{sda_s1_r, sda_s2_r, sda_s3_r, sda_f_r} <= 4'hF;
		end else begin
			{scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_i, scl_s1_r, scl_s2_r};
			{sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_i, sda_s1_r, sda_s2_r};
			if (scl_s2_r == scl_s3_r)
				scl_f_r <= scl_s3_r;
			if (sda_s2_r == sda_s3_r)
				sda_f_r <= sda_s3_r;
		end
	end

	// Edge events of the filtered lines
	assign scl_rise = (scl_s2_r == scl_s3_r) && scl_s3_r && !scl_f_r;
	assign scl_fall = (scl_s2_r == scl_s3_r) && !scl_s3_r && scl_f_r;
	assign start_c = scl_f_r && (sda_s2_r == sda_s3_r) && !sda_s3_r && sda_f_r;
	assign stop_c = scl_f_r && (sda_s2_r == sda_s3_r) && sda_s3_r && !sda_f_r;

	// ****************************************
	// Register storage helpers
	// ****************************************
	function automatic logic [7:0] reset_value(input logic [7:0] a);
		case (a)
			OFF_CONFIG_ZERO: reset_value = RST_CONFIG_ZERO;
			OFF_PROX_CONFIG_ZERO: reset_value = RST_PROX_CONFIG_ZERO;
			OFF_PROX_CONFIG_ONE: reset_value = RST_PROX_CONFIG_ONE;
			OFF_PROX_CFG2: reset_value = RST_PROX_CFG2;
			OFF_CONFIG_ONE: reset_value = RST_CONFIG_ONE;
			OFF_CONFIG_THREE: reset_value = RST_CONFIG_THREE;
			OFF_CONFIG_SIX: reset_value = RST_CONFIG_SIX;
			OFF_TRIM_CTRL: reset_value = RST_TRIM_CTRL;
			OFF_LIGHT_SETUP: reset_value = RST_LIGHT_SETUP;
			OFF_PROX_TRIM_AUX: reset_value = RST_PROX_TRIM_AUX;
			default: reset_value = 8'h00;
		endcase
	endfunction : reset_value

	function automatic logic writable(input logic [7:0] a);
		writable = (a >= OFF_STATE_ENABLES && a <= OFF_PROX_CFG2) ||
			a == OFF_CONFIG_ONE || a == OFF_SOFT_RESET || a == OFF_PROX_WAIT ||
			a == OFF_CONFIG_THREE || a == OFF_CONFIG_SIX || a == OFF_PROX_OFS_LO ||
			a == OFF_PROX_OFS_HI || a == OFF_TRIM_START || a == OFF_TRIM_EXT ||
			a == OFF_TRIM_CTRL || a == OFF_TRIM_STATE || a == OFF_IRQ_MASK ||
			a == OFF_LIGHT_SETUP || a == OFF_PROX_TRIM_AUX;
	endfunction : writable

	// ****************************************
	// Serial slave and register file
	// ****************************************
	ser_state_t ser_r, ser_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
	logic ack_r, ack_nxt;
	logic [7:0] regs_r [128];
	logic [7:0] regs_nxt [128];
	logic [7:0] flags_r, flags_nxt;
	logic [7:0] rd_byte;
	logic flags_read;
	logic prox_hit, light_hit;
	sense_result_t data_r, data_nxt;

	// Read mux over stored, live and identity bytes
	always_comb begin
		case (ptr_r)
			OFF_REVISION: rd_byte = REVISION_VAL;
			OFF_TYPE_CODE: rd_byte = TYPE_VAL;
			OFF_VERSION_TWO: rd_byte = VERSION_VAL;
			OFF_FLAGS: rd_byte = flags_r;
			OFF_LIGHT_B0: rd_byte = data_r.light[7:0];
			OFF_LIGHT_B1: rd_byte = data_r.light[15:8];
			OFF_LIGHT_B2: rd_byte = data_r.light[23:16];
			OFF_IR_B0: rd_byte = data_r.ir[7:0];
			OFF_IR_B1: rd_byte = data_r.ir[15:8];
			OFF_IR_B2: rd_byte = data_r.ir[23:16];
			OFF_PROX_B0: rd_byte = data_r.prox[7:0];
			OFF_PROX_B1: rd_byte = data_r.prox[15:8];
			default: rd_byte = (ptr_r[7] && writable(ptr_r)) ? regs_r[ptr_r[6:0]] : 8'h00;
		endcase
	end

	// Byte framing: sample on rise, advance on fall, ack in ninth slot
	always_comb begin
		ser_nxt = ser_r;
		bit_nxt = bit_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		ack_nxt = ack_r;
		regs_nxt = regs_r;
		flags_read = 1'b0;
		if (start_c) begin
			ser_nxt = SER_DEV;
			// Start's own SCL fall wraps the count to bit zero
			bit_nxt = 4'hF;
			ack_nxt = 1'b0;
		end else if (stop_c) begin
			ser_nxt = SER_IDLE;
			ack_nxt = 1'b0;
		end else if (ser_r != SER_IDLE && scl_rise) begin
			if (bit_r < 4'h8)
				shift_nxt = {shift_r[6:0], sda_f_r};
			else if (ser_r == SER_RD && sda_s3_r)
				ser_nxt = SER_IDLE; // Master ended the read
		end else if (ser_r != SER_IDLE && scl_fall) begin
			if (bit_r == 4'h7) begin
				bit_nxt = 4'h8;
				ack_nxt = 1'b1;
				case (ser_r)
					SER_DEV: begin
						if (shift_r[7:1] != DEV_ADDR) begin
							ser_nxt = SER_IDLE;
							ack_nxt = 1'b0;
						end
					end
					SER_PTR: ptr_nxt = shift_r;
					SER_WR: begin
						if (ptr_r[7] && writable(ptr_r))
							regs_nxt[ptr_r[6:0]] = shift_r;
						ptr_nxt = ptr_r + 8'h01;
					end
					SER_RD: ack_nxt = 1'b0;
					default: ack_nxt = 1'b0;
				endcase
			end else if (bit_r == 4'h8) begin
				bit_nxt = 4'h0;
				ack_nxt = 1'b0;
				case (ser_r)
					SER_DEV: ser_nxt = shift_r[0] ? SER_RD : SER_PTR;
					SER_PTR: ser_nxt = SER_WR;
					default: ser_nxt = ser_r;
				endcase
				if (ser_r == SER_RD || (ser_r == SER_DEV && shift_r[0])) begin
					tx_nxt = rd_byte;
					flags_read = (ptr_r == OFF_FLAGS);
					ptr_nxt = ptr_r + 8'h01;
				end
			end else begin
				bit_nxt = bit_r + 4'h1;
				tx_nxt = {tx_r[6:0], 1'b0};
			end
		end
	end

	// Flags: hardware set wins over the clear by read
	always_comb begin
		flags_nxt = flags_r;
		if (flags_read)
			flags_nxt = 8'h00;
		if (prox_hit)
			flags_nxt[BIT_PROX_IRQ] = 1'b1;
		if (light_hit)
			flags_nxt[BIT_LIGHT_IRQ] = 1'b1;
	end

	// Register the serial and register file state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ser_r <= SER_IDLE;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= 8'h00;
			ack_r <= 1'b0;
			flags_r <= 8'h00;
			for (int i = 0; i < 128; i++)
				regs_r[i] <= reset_value(8'h80 | 8'(i));
		end else begin
			ser_r <= ser_nxt;
			bit_r <= bit_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			ack_r <= ack_nxt;
			flags_r <= flags_nxt;
			regs_r <= regs_nxt;
		end
	end

	// Open-drain pins only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe = ack_r || (ser_r == SER_RD && bit_r < 4'h8 && !tx_r[7]);

	// ****************************************
	// Decoded control fields
	// ****************************************
	logic [7:0] en_v, config_zero_v, config_three_v, debounce_counts_v, mask_v;
	logic [23:0] light_lo_thr, light_hi_thr;
	logic [15:0] prox_lo_thr, prox_hi_thr;
	logic wide_prox_mode;
	assign en_v = regs_r[OFF_STATE_ENABLES[6:0]];
	assign config_zero_v = regs_r[OFF_CONFIG_ZERO[6:0]];
	assign config_three_v = regs_r[OFF_CONFIG_THREE[6:0]];
	assign debounce_counts_v = regs_r[OFF_DEBOUNCE[6:0]];
	assign mask_v = regs_r[OFF_IRQ_MASK[6:0]];
	assign wide_prox_mode = config_three_v[BIT_WIDE_PROX];
	assign light_lo_thr = {regs_r[OFF_LIGHT_LO_MSB[6:0]], regs_r[OFF_LIGHT_LO_LSB[6:0]], 8'h00};
	assign light_hi_thr = {regs_r[OFF_LIGHT_HI_MSB[6:0]], regs_r[OFF_LIGHT_HI_LSB[6:0]], 8'h00};
	assign prox_lo_thr = {wide_prox_mode ? regs_r[OFF_PROX_LO_MSB[6:0]][7:4] : 4'h0,
		regs_r[OFF_PROX_LO_MSB[6:0]][3:0], regs_r[OFF_PROX_LO_LSB[6:0]]};
	assign prox_hi_thr = {wide_prox_mode ? regs_r[OFF_PROX_HI_MSB[6:0]][7:4] : 4'h0,
		regs_r[OFF_PROX_HI_MSB[6:0]][3:0], regs_r[OFF_PROX_HI_LSB[6:0]]};

	// ****************************************
	// Measurement sequencer
	// ****************************************
	seq_state_t seq_r, seq_nxt;
	logic [31:0] tick_r, tick_nxt;
	logic [11:0] steps_r, steps_nxt;
	logic step_done, phase_end;
	logic [11:0] target;
	logic [5:0] pcnt_r, pcnt_nxt, lcnt_r, lcnt_nxt, light_need;
	logic prox_out, light_out, prox_end, light_end;

	// Steps of the current phase, minus one
	always_comb begin
		case (seq_r)
			SEQ_PROX: target = {4'h0, regs_r[OFF_PROX_INTEG[6:0]]};
			SEQ_LIGHT: target = {4'h0, regs_r[OFF_LIGHT_INTEG[6:0]]};
			SEQ_PWAIT: target = config_zero_v[BIT_PROX_X16] ?
				({4'h0, regs_r[OFF_PROX_WAIT[6:0]]} << WAIT_X16) + 12'hF :
				{4'h0, regs_r[OFF_PROX_WAIT[6:0]]};
			SEQ_LWAIT: target = config_zero_v[BIT_LIGHT_X16] ?
				({4'h0, regs_r[OFF_LIGHT_WAIT[6:0]]} << WAIT_X16) + 12'hF :
				{4'h0, regs_r[OFF_LIGHT_WAIT[6:0]]};
			default: target = 12'h000;
		endcase
	end

	assign step_done = (tick_r == 32'(STEP_CYC - 1));
	assign phase_end = step_done && (steps_r == target);
	assign prox_end = (seq_r == SEQ_PROX) && phase_end;
	assign light_end = (seq_r == SEQ_LIGHT) && phase_end;

	// Phase order: prox, prox wait, light, light wait, repeat
	always_comb begin
		seq_nxt = seq_r;
		tick_nxt = step_done ? 32'h0 : tick_r + 32'h1;
		steps_nxt = step_done ? steps_r + 12'h001 : steps_r;
		if (!en_v[BIT_POWER_ON]) begin
			seq_nxt = SEQ_IDLE;
		end else begin
			case (seq_r)
				SEQ_IDLE: begin
					if (en_v[BIT_PROX_ON])
						seq_nxt = SEQ_PROX;
					else if (en_v[BIT_LIGHT_ON])
						seq_nxt = SEQ_LIGHT;
				end
				SEQ_PROX: begin
					if (phase_end)
						seq_nxt = en_v[BIT_PROX_WAIT_ON] ? SEQ_PWAIT :
							en_v[BIT_LIGHT_ON] ? SEQ_LIGHT : SEQ_IDLE;
				end
				SEQ_PWAIT: begin
					if (phase_end)
						seq_nxt = en_v[BIT_LIGHT_ON] ? SEQ_LIGHT : SEQ_IDLE;
				end
				SEQ_LIGHT: begin
					if (phase_end)
						seq_nxt = en_v[BIT_LIGHT_WAIT_ON] ? SEQ_LWAIT : SEQ_IDLE;
				end
				SEQ_LWAIT: begin
					if (phase_end)
						seq_nxt = SEQ_IDLE;
				end
				default: seq_nxt = SEQ_IDLE;
			endcase
		end
		if (seq_nxt != seq_r || seq_r == SEQ_IDLE) begin
			tick_nxt = 32'h0;
			steps_nxt = 12'h000;
		end
	end

	// ****************************************
	// Threshold compare and persistence
	// ****************************************
	// below low or above high
	assign prox_out = conv_result.prox < prox_lo_thr || conv_result.prox > prox_hi_thr;
	assign light_out = conv_result.light < light_lo_thr || conv_result.light > light_hi_thr;

	// light persistence need; code 15 needs 60
	always_comb begin
		if (debounce_counts_v[3:0] < 4'h4)
			light_need = {2'b00, debounce_counts_v[3:0]};
		else
			light_need = ({2'b00, debounce_counts_v[3:0]} - 6'h03) * 6'h05;
	end

	// Counters advance only at the end of their own integration
	always_comb begin
		pcnt_nxt = pcnt_r;
		lcnt_nxt = lcnt_r;
		data_nxt = data_r;
		prox_hit = 1'b0;
		light_hit = 1'b0;
		if (prox_end) begin
			data_nxt.prox = conv_result.prox;
			pcnt_nxt = !prox_out ? 6'h00 : (pcnt_r == 6'h3F ? pcnt_r : pcnt_r + 6'h01);
			prox_hit = (debounce_counts_v[7:4] == 4'h0) || (prox_out && pcnt_nxt >= {2'b00, debounce_counts_v[7:4]});
		end
		if (light_end) begin
			data_nxt.light = conv_result.light;
			data_nxt.ir = conv_result.ir;
			lcnt_nxt = !light_out ? 6'h00 : (lcnt_r == 6'h3F ? lcnt_r : lcnt_r + 6'h01);
			light_hit = (debounce_counts_v[3:0] == 4'h0) || (light_out && lcnt_nxt >= light_need);
		end
	end

	// Register sequencer, counters and results
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			seq_r <= SEQ_IDLE;
			tick_r <= 32'h0;
			steps_r <= 12'h000;
			pcnt_r <= 6'h00;
			lcnt_r <= 6'h00;
			data_r <= '0;
		end else begin
			seq_r <= seq_nxt;
			tick_r <= tick_nxt;
			steps_r <= steps_nxt;
			pcnt_r <= pcnt_nxt;
			lcnt_r <= lcnt_nxt;
			data_r <= data_nxt;
		end
	end

	// Status outputs and masked interrupt pin
	assign osc_run = en_v[BIT_POWER_ON];
	assign prox_integ = (seq_r == SEQ_PROX);
	assign light_integ = (seq_r == SEQ_LIGHT);
	assign int_o = 1'b0;
	assign int_oe = (flags_r[BIT_PROX_IRQ] && mask_v[BIT_PROX_IRQ]) ||
		(flags_r[BIT_LIGHT_IRQ] && mask_v[BIT_LIGHT_IRQ]);

	// ****************************************
	// Assertions
	// ****************************************
	power_off_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!en_v[BIT_POWER_ON] |=> seq_r == SEQ_IDLE) else $error("sequencer ran with power off");
	light_needs_on_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(light_integ) |-> $past(en_v[BIT_LIGHT_ON])) else $error("light ran while off");
	prox_needs_on_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(prox_integ) |-> $past(en_v[BIT_PROX_ON])) else $error("prox ran while off");
	lwait_needs_on_a: assert property (@(posedge ref_clk) disable iff (rst)
		seq_r != SEQ_LWAIT && seq_nxt == SEQ_LWAIT |-> en_v[BIT_LIGHT_WAIT_ON])
		else $error("light wait while off");
	pwait_needs_on_a: assert property (@(posedge ref_clk) disable iff (rst)
		seq_r != SEQ_PWAIT && seq_nxt == SEQ_PWAIT |-> en_v[BIT_PROX_WAIT_ON])
		else $error("prox wait while off");
	step_count_a: assert property (@(posedge ref_clk) disable iff (rst)
		step_done && seq_r == seq_nxt |=> tick_r == 32'h0 && steps_r == $past(steps_r) + 12'h001)
		else $error("step counter slipped");
	light_thresh_a: assert property (@(posedge ref_clk) disable iff (rst)
		light_lo_thr[7:0] == 8'h00 && light_hi_thr[7:0] == 8'h00) else $error("threshold low byte");
	narrow_prox_a: assert property (@(posedge ref_clk) disable iff (rst)
		!wide_prox_mode |-> prox_lo_thr[15:12] == 4'h0 && prox_hi_thr[15:12] == 4'h0)
		else $error("narrow prox threshold wide");
	debounce_counts_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
		prox_end && !prox_out |=> pcnt_r == 6'h00) else $error("prox count not cleared");
	flag_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		prox_hit |=> flags_r[BIT_PROX_IRQ]) else $error("prox flag missed");
	light_need_a: assert property (@(posedge ref_clk) disable iff (rst)
		debounce_counts_v[3:0] == 4'hF |-> light_need == LIGHT_DEBOUNCE_COUNTS_MAX) else $error("code 15 need wrong");

endmodule : light_prox_control_regs

/* serial_host.sv */
/*
 * Two-wire bus master model that drives the sensor's serial pins.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/1ps
module serial_host
	import light_prox_pkg::*;
#(
	parameter int H = 12
) (
	input wire logic ref_clk, // Bench clock
	input wire logic sda_line, // Resolved data wire
	output logic scl, // Serial clock pin
	output logic sda_low // High pulls data low
);
	logic [7:0] nacks = 8'h00; // Missing device acks
	logic [7:0] q;
	logic s;
	// Both pins released at time zero
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : hold
	// Data moves only while the clock is low, sampled at clock high end
	task automatic bit_io(input logic b, output logic smp);
		hold(H / 2);
		sda_low <= !b;
		hold(H / 2);
		scl <= 1'b1;
		hold(H);
		smp = sda_line;
		scl <= 1'b0;
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(last, s);
	endtask : xfer
	task automatic wr_byte(input logic [7:0] d);
		xfer(d, 1'b1);
		if (s !== 1'b0) nacks = nacks + 8'h01;
	endtask : wr_byte
	// Start also serves as a repeated start after a released ack slot
	task automatic start();
		hold(H / 2);
		scl <= 1'b1;
		hold(H);
		sda_low <= 1'b1;
		hold(H);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		hold(H / 2);
		sda_low <= 1'b1;
		hold(H / 2);
		scl <= 1'b1;
		hold(H);
		sda_low <= 1'b0;
		hold(H);
	endtask : stop
	task automatic write_reg(input logic [7:0] off, input logic [7:0] val);
		start();
		wr_byte({DEV_ADDR, 1'b0});
		wr_byte(off);
		wr_byte(val);
		stop();
	endtask : write_reg
	// Single byte read; the master's nack ends it
	task automatic read_reg(input logic [7:0] off, output logic [7:0] d);
		start();
		wr_byte({DEV_ADDR, 1'b0});
		wr_byte(off);
		start();
		wr_byte({DEV_ADDR, 1'b1});
		xfer(8'hFF, 1'b1);
		d = q;
		stop();
	endtask : read_reg
endmodule : serial_host

/* light_prox_control_regs_tb.sv */
/*
 * Self-checking bench: register access, persistence filters, flags.
 * Assumes a shortened step of 20 clocks and the serial_host model.
 */
`timescale 1ns/1ps
module light_prox_control_regs_tb;
	import light_prox_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic scl, sda_low, sda_oe, int_oe, osc_run, light_integ, prox_integ, integ_d;
	logic sda_drv, int_drv;
	logic [7:0] cnt = 8'h00;
	logic [7:0] q;
	int mismatches = 0;
	int n_tests = 0;
	int i;
	// Light below its low bound, prox above its narrow high bound
	sense_result_t res = '{light: 24'h1233FF, ir: 24'h000000, prox: 16'h0200};
	wire sda_line = !(sda_low | sda_oe);
	// Offset, written value, expected readback
	logic [23:0] rows [15] = '{24'h801E1E, 24'h917705, 24'h205500, 24'h810202, 24'h820202,
		24'h843434, 24'h851212, 24'h86FFFF, 24'h87FFFF, 24'h881010, 24'h891010,
		24'h8A0000, 24'h8BF1F1, 24'h8C3434, 24'hDD3030};
	logic [15:0] defs [6] = '{16'h8D50, 16'h8E8F, 16'h9368, 16'hAE3F, 16'hF660, 16'h8100};
	always #12.5 ref_clk = ~ref_clk;
	serial_host host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
	light_prox_control_regs #(.STEP_CYC(20), .REVISION_VAL(8'h05)) dut (.ref_clk(ref_clk),
		.rst(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv), .sda_oe(sda_oe), .int_o(int_drv),
		.int_oe(int_oe), .conv_result(res), .osc_run(osc_run), .light_integ(light_integ),
		.prox_integ(prox_integ));
	// Completed integrations since power-on, to judge persistence counts
	always @(posedge ref_clk) begin
		integ_d <= prox_integ | light_integ;
		if (osc_run !== 1'b1) cnt <= 8'h00;
		else if (integ_d && !(prox_integ | light_integ)) cnt <= cnt + 8'h01;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic rd(input logic [7:0] off, input logic [7:0] exp);
		host.read_reg(off, q);
		check(q, exp);
	endtask : rd
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : final_report
	// Run until the interrupt pin pulls, then stop and read flags twice
	task automatic debounce_counts_run(input logic [7:0] en, input logic [7:0] need, input logic [7:0] fl);
		host.write_reg(OFF_STATE_ENABLES, en);
		for (i = 0; i < 4000 && int_oe !== 1'b1; i++) @(posedge ref_clk);
		if (i == 4000) begin
			mismatches++;
			final_report();
		end
		// Let the fall of the last integration reach the count
		@(posedge ref_clk);
		check(cnt, need);
		host.write_reg(OFF_STATE_ENABLES, 8'h00);
		rd(OFF_FLAGS, fl);
		rd(OFF_FLAGS, 8'h00);
		check({7'h00, int_oe}, 8'h00);
		$display("test persistence %h done", en);
	endtask : debounce_counts_run
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		// prox period row keeps three steps, far above the pulse time
		foreach (rows[k]) begin
			host.write_reg(rows[k][23:16], rows[k][15:8]);
			rd(rows[k][23:16], rows[k][7:0]);
		end
		check({7'h00, osc_run}, 8'h00);
		check(host.nacks, 8'h00);
		$display("test registers done");
		// Prox code 3 against narrow high bound 0x100
		debounce_counts_run(8'h05, 8'h03, 8'h20);
		// Light code 4 needs five, low bound 0x123400
		debounce_counts_run(8'h03, 8'h05, 8'h10);
		rd(OFF_LIGHT_B2, 8'h12);
		rd(OFF_PROX_B1, 8'h02);
		// Wide mode: prox 0x0050 is inside the narrow window, below wide low 0x1010
		host.write_reg(OFF_CONFIG_THREE, 8'h09);
		host.write_reg(OFF_DEBOUNCE, 8'h14);
		res.prox <= 16'h0050;
		debounce_counts_run(8'h15, 8'h01, 8'h20);
		rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		foreach (defs[k]) rd(defs[k][15:8], defs[k][7:0]);
		check({7'h00, osc_run}, 8'h00);
		check({6'h00, sda_drv, int_drv}, 8'h00);
		$display("test reset done");
		final_report();
	end
endmodule : light_prox_control_regs_tb
